// file: rtl/dspt_timer.sv
/*
  Dual-slope PWM timer with two compare channels, 16-bit registers
  reached as byte pairs through one shared high-byte latch.
  Assumes an AHB-Lite master on sys_clk and pins driven from the
  output and enable signals by the pad logic outside.
*/
// Implementation choices: register access over AHB-Lite and the placing of the registers.
// How it works
// - Mode 8 takes top from capture, mode 9 from compare A.
// - Counter runs up from 0x0000 to top, then back down.
// - Top value is held for exactly one timer tick.
// - Non-inverting clears on up match, sets on down match.
// - Output mode two gives normal PWM, three gives inverted PWM.
// - The pin is only driven when its direction bit is set.
// - Active compare values load from buffers at bottom.
// - Overflow flag sets in the tick of the bottom update.
// - Compare-A or capture flag sets when the counter reaches top.
// - A channel flag sets when the count equals its compare value.
// - Top below a compare value means that channel never matches.
// - Top may range from 0x0003 up to 0xffff.
// - Non-inverting compare at bottom gives steady low, at top steady high.
// - Period is two times top ticks; tick is clock over 1 to 1024.
// - All logic is on sys_clk; the tick is only an enable.
// - Sixteen-bit registers share one 8-bit high-byte latch.
// - A low-byte write loads latch and low byte together.
// - A counter or capture low-byte read copies the high byte into the latch.
// - Compare reads return both bytes directly, latch untouched.
// - Mode 0 disconnects; mode 1 toggles A when top bit set.
// - Any connected output mode overrides the pin's port value.
`timescale 1ns/10ps
`default_nettype none
`include "dspt_consts.svh"
module dspt_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] haddr,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic waveOutA,
    output logic waveOutAOe,
    output logic waveOutB,
    output logic waveOutBOe
);
    import dspt_pkg::*;

    // ---------------------------------------------
    // Bus front end
    // ---------------------------------------------
    dspt_regbus_if regBus ();

    dspt_ahb_slave u_bus (
        .sys_clk(sys_clk),
        .rst(rst),
        .haddr(haddr),
        .hsel(hsel),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .regs(regBus.bus)
    );

    // ---------------------------------------------
    // State
    // ---------------------------------------------
    dspt_com_type compare_output_mode [2];
    logic [3:0] waveform_mode_sel;
    logic [2:0] prescaleSel;
    logic [1:0] pin_direction_bit;
    logic [1:0] portBit;
    logic [3:0] flagBits;
    logic [3:0] flagSet;
    logic [3:0] flagClr;
    dspt_word_type timer_count;
    dspt_word_type compareBuf [2];
    dspt_word_type compare_value [2];
    dspt_word_type capture_top_value;
    dspt_word_type topValue;
    logic [7:0] highLatch;
    logic countUp;
    logic [9:0] prescaleCount;
    logic [9:0] prescaleLast;
    logic timer_tick;
    logic [1:0] wave_out;
    logic [1:0] pinOut;
    logic [1:0] pinOe;
    logic [1:0] match;
    logic running;
    logic atTop;
    logic atBottom;
    logic matchUp;
    logic step;
    logic wrLo;
    logic [7:0] wdata;
    dspt_word_type wordIn;

    assign wdata = regBus.wdata;
    assign wordIn = {highLatch, wdata};
    assign wrLo = regBus.wrStb;

    // ---------------------------------------------
    // Control registers
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            compare_output_mode[0] <= COM_OFF;
            compare_output_mode[1] <= COM_OFF;
            waveform_mode_sel <= 4'h0;
            prescaleSel <= `DSPT_PRESC_STOP;
            pin_direction_bit <= 2'b00;
            portBit <= 2'b00;
        end else if (regBus.wrStb) begin
            if (regBus.addr == `DSPT_OFS_CTRL_A) begin
                compare_output_mode[0] <= dspt_com_type'(wdata[`DSPT_COM_A_POS +: 2]);
                compare_output_mode[1] <= dspt_com_type'(wdata[`DSPT_COM_B_POS +: 2]);
            end
            if (regBus.addr == `DSPT_OFS_CTRL_B) begin
                waveform_mode_sel <= wdata[3:0];
                prescaleSel <= wdata[`DSPT_PRESC_POS +: 3];
            end
            if (regBus.addr == `DSPT_OFS_PIN) begin
                pin_direction_bit <= wdata[1:0];
                portBit <= wdata[3:2];
            end
        end
    end

    // ---------------------------------------------
    // Shared high-byte latch
    // ---------------------------------------------
    // A second 16-bit access between the two halves of another one
    // corrupts it; software must keep the pair atomic.
    // one shared latch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            highLatch <= `DSPT_RST_BYTE;
        end else if (regBus.wrStb && (regBus.addr == `DSPT_OFS_CNT_HI
                || regBus.addr == `DSPT_OFS_CMPA_HI
                || regBus.addr == `DSPT_OFS_CMPB_HI
                || regBus.addr == `DSPT_OFS_CAP_HI)) begin
            highLatch <= wdata;
        end else if (regBus.rdStb && regBus.addr == `DSPT_OFS_CNT_LO) begin
            highLatch <= timer_count[15:8];
        end else if (regBus.rdStb && regBus.addr == `DSPT_OFS_CAP_LO) begin
            highLatch <= capture_top_value[15:8];
        end
    end

    // ---------------------------------------------
    // Read mux
    // ---------------------------------------------
    always_comb begin
        unique case (regBus.addr)
            `DSPT_OFS_CTRL_A: regBus.rdata = {compare_output_mode[0],
                                              compare_output_mode[1], 4'h0};
            `DSPT_OFS_CTRL_B: regBus.rdata = {1'b0, prescaleSel, waveform_mode_sel};
            `DSPT_OFS_PIN: regBus.rdata = {4'h0, portBit, pin_direction_bit};
            `DSPT_OFS_FLAGS: regBus.rdata = {4'h0, flagBits};
            `DSPT_OFS_CNT_LO: regBus.rdata = timer_count[7:0];
            `DSPT_OFS_CNT_HI: regBus.rdata = highLatch;
            `DSPT_OFS_CMPA_LO: regBus.rdata = compareBuf[0][7:0];
            `DSPT_OFS_CMPA_HI: regBus.rdata = compareBuf[0][15:8];
            `DSPT_OFS_CMPB_LO: regBus.rdata = compareBuf[1][7:0];
            `DSPT_OFS_CMPB_HI: regBus.rdata = compareBuf[1][15:8];
            `DSPT_OFS_CAP_LO: regBus.rdata = capture_top_value[7:0];
            `DSPT_OFS_CAP_HI: regBus.rdata = highLatch;
            default: regBus.rdata = 8'h00;
        endcase
    end

    // ---------------------------------------------
    // Prescaler
    // ---------------------------------------------
    always_comb begin
        unique case (prescaleSel)
            `DSPT_PRESC_1: prescaleLast = `DSPT_LAST_1;
            `DSPT_PRESC_8: prescaleLast = `DSPT_LAST_8;
            `DSPT_PRESC_64: prescaleLast = `DSPT_LAST_64;
            `DSPT_PRESC_256: prescaleLast = `DSPT_LAST_256;
            `DSPT_PRESC_1024: prescaleLast = `DSPT_LAST_1024;
            default: prescaleLast = `DSPT_LAST_1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !running || prescaleSel == `DSPT_PRESC_STOP
                || prescaleSel > `DSPT_PRESC_1024) begin
            prescaleCount <= 10'h000;
            timer_tick <= 1'b0;
        end else if (prescaleCount == prescaleLast) begin
            prescaleCount <= 10'h000;
            timer_tick <= 1'b1;
        end else begin
            prescaleCount <= prescaleCount + 10'h001;
            timer_tick <= 1'b0;
        end
    end

    // ---------------------------------------------
    // Counter
    // ---------------------------------------------
    // Only modes 8 and 9 run; any other mode holds the counter.
    assign running = waveform_mode_sel == `DSPT_MODE_TOP_CAPTURE
                  || waveform_mode_sel == `DSPT_MODE_TOP_CMPA;
    assign topValue = (waveform_mode_sel == `DSPT_MODE_TOP_CMPA)
                    ? compare_value[0] : capture_top_value;
    assign atTop = timer_count == topValue;
    assign atBottom = timer_count == `DSPT_BOTTOM;
    assign step = timer_tick && running;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_count <= `DSPT_RST_WORD;
            countUp <= 1'b1;
        end else if (wrLo && regBus.addr == `DSPT_OFS_CNT_LO) begin
            timer_count <= wordIn;
        end else if (step) begin
            if (atBottom) begin
                timer_count <= timer_count + 16'h0001;
                countUp <= 1'b1;
            end else if (atTop) begin
                timer_count <= timer_count - 16'h0001;
                countUp <= 1'b0;
            end else if (countUp) begin
                timer_count <= timer_count + 16'h0001;
            end else begin
                timer_count <= timer_count - 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            capture_top_value <= `DSPT_RST_WORD;
        end else if (wrLo && regBus.addr == `DSPT_OFS_CAP_LO) begin
            capture_top_value <= wordIn;
        end
    end

    // A match at top counts as down-counting and at bottom as up-counting,
    // so compare at top or bottom gives a steady level, not a spike.
    // extreme compare values
    assign matchUp = atBottom ? 1'b1 : (atTop ? 1'b0 : countUp);

    // ---------------------------------------------
    // Compare channels
    // ---------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam logic [7:0] OFS_LO = (ch == 0) ? `DSPT_OFS_CMPA_LO : `DSPT_OFS_CMPB_LO;
        logic connected;

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                compareBuf[ch] <= `DSPT_RST_WORD;
            end else if (wrLo && regBus.addr == OFS_LO) begin
                compareBuf[ch] <= wordIn;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                compare_value[ch] <= `DSPT_RST_WORD;
            end else if (!running || (step && atBottom)) begin
                compare_value[ch] <= compareBuf[ch];
            end
        end

        assign match[ch] = step && timer_count == compare_value[ch];

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                wave_out[ch] <= 1'b0;
            end else if (match[ch]) begin
                unique case (compare_output_mode[ch])
                    COM_NONINV: wave_out[ch] <= !matchUp;
                    COM_INV: wave_out[ch] <= matchUp;
                    COM_TOGGLE: wave_out[ch] <= (ch == 0 && waveform_mode_sel[3])
                                              ? !wave_out[ch] : wave_out[ch];
                    COM_OFF: wave_out[ch] <= wave_out[ch];
                endcase
            end
        end

        assign connected = compare_output_mode[ch] == COM_NONINV
                        || compare_output_mode[ch] == COM_INV
                        || (compare_output_mode[ch] == COM_TOGGLE && ch == 0
                            && waveform_mode_sel[3]);

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                pinOut[ch] <= 1'b0;
                pinOe[ch] <= 1'b0;
            end else begin
                pinOut[ch] <= connected ? wave_out[ch] : portBit[ch];
                pinOe[ch] <= pin_direction_bit[ch];
            end
        end
    end

    // ---------------------------------------------
    // Flags
    // ---------------------------------------------
    // overflow at bottom update
    assign flagSet[`DSPT_FLAG_OVF] = step && atBottom;
    assign flagSet[`DSPT_FLAG_CMPA] = match[0]
        || (step && atTop && waveform_mode_sel == `DSPT_MODE_TOP_CMPA);
    assign flagSet[`DSPT_FLAG_CMPB] = match[1];
    assign flagSet[`DSPT_FLAG_CAP] = step && atTop
        && waveform_mode_sel == `DSPT_MODE_TOP_CAPTURE;
    assign flagClr = (regBus.wrStb && regBus.addr == `DSPT_OFS_FLAGS) ? wdata[3:0] : 4'h0;

    // Set beats a same-cycle write-one clear so no event is lost.
    for (genvar f = 0; f < 4; f++) begin : g_flag
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                flagBits[f] <= 1'b0;
            end else begin
                flagBits[f] <= flagSet[f] || (flagBits[f] && !flagClr[f]);
            end
        end
    end

    // ---------------------------------------------
    // Pins
    // ---------------------------------------------
    assign waveOutA = pinOut[0];
    assign waveOutAOe = pinOe[0];
    assign waveOutB = pinOut[1];
    assign waveOutBOe = pinOe[1];
endmodule : dspt_timer
`default_nettype wire

// file: rtl/dspt_consts.svh
/*
  Offsets, field positions, reset values and prescaler counts of the
  dual-slope PWM timer. Assumes a 32-bit bus with one register per word.
*/
`ifndef DSPT_CONSTS_SVH
`define DSPT_CONSTS_SVH
`define DSPT_OFS_CTRL_A 8'h00
`define DSPT_OFS_CTRL_B 8'h04
`define DSPT_OFS_PIN 8'h08
`define DSPT_OFS_FLAGS 8'h0c
`define DSPT_OFS_CNT_LO 8'h10
`define DSPT_OFS_CNT_HI 8'h14
`define DSPT_OFS_CMPA_LO 8'h18
`define DSPT_OFS_CMPA_HI 8'h1c
`define DSPT_OFS_CMPB_LO 8'h20
`define DSPT_OFS_CMPB_HI 8'h24
`define DSPT_OFS_CAP_LO 8'h28
`define DSPT_OFS_CAP_HI 8'h2c
`define DSPT_COM_A_POS 6
`define DSPT_COM_B_POS 4
`define DSPT_PRESC_POS 4
`define DSPT_FLAG_OVF 0
`define DSPT_FLAG_CMPA 1
`define DSPT_FLAG_CMPB 2
`define DSPT_FLAG_CAP 3
`define DSPT_MODE_TOP_CAPTURE 4'h8
`define DSPT_MODE_TOP_CMPA 4'h9
`define DSPT_BOTTOM 16'h0000
`define DSPT_RST_BYTE 8'h00
`define DSPT_RST_WORD 16'h0000
`define DSPT_PRESC_STOP 3'h0
`define DSPT_PRESC_1 3'h1
`define DSPT_PRESC_8 3'h2
`define DSPT_PRESC_64 3'h3
`define DSPT_PRESC_256 3'h4
`define DSPT_PRESC_1024 3'h5
`define DSPT_LAST_1 10'h000
`define DSPT_LAST_8 10'h007
`define DSPT_LAST_64 10'h03f
`define DSPT_LAST_256 10'h0ff
`define DSPT_LAST_1024 10'h3ff
`endif

// file: rtl/dspt_pkg.sv
/*
  Types of the dual-slope PWM timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dspt_pkg;
    typedef logic [15:0] dspt_word_type;
    typedef enum logic [1:0] {
        COM_OFF,
        COM_TOGGLE,
        COM_NONINV,
        COM_INV
    } dspt_com_type;
endpackage : dspt_pkg
`default_nettype wire

// file: rtl/dspt_regbus_if.sv
/*
  Byte register strobes between the bus slave and the timer core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface dspt_regbus_if;
    logic wrStb;
    logic rdStb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport bus (output wrStb, output rdStb, output addr, output wdata, input rdata);
    modport regs (input wrStb, input rdStb, input addr, input wdata, output rdata);
endinterface : dspt_regbus_if
`default_nettype wire

// file: rtl/dspt_ahb_slave.sv
/*
  AHB-Lite slave front end: one wait state per transfer, then OKAY.
  Assumes single word transfers and that this slave's hreadyout is hready.
*/
`timescale 1ns/10ps
`default_nettype none
module dspt_ahb_slave (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] haddr,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    dspt_regbus_if.bus regs
);
    logic pend;
    logic writeQ;
    logic [7:0] addrQ;

    // ---------------------------------------------
    // Transfer tracking
    // ---------------------------------------------
    // The wait state lets read data come from a flip-flop.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend <= 1'b0;
            writeQ <= 1'b0;
            addrQ <= 8'h00;
            hreadyout <= 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            pend <= 1'b1;
            writeQ <= hwrite;
            addrQ <= haddr[7:0];
            hreadyout <= 1'b0;
        end else begin
            pend <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (pend && !writeQ) begin
                hrdata <= {24'h00_0000, regs.rdata};
            end
        end
    end

    assign regs.wrStb = pend && writeQ;
    assign regs.rdStb = pend && !writeQ;
    assign regs.addr = addrQ;
    assign regs.wdata = hwdata[7:0];
endmodule : dspt_ahb_slave
`default_nettype wire

// file: tb/dspt_timer_assertions.sv
/* Checker of the timer's bus handshake and pin enables.
   Assumes it is bound to the timer top module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module dspt_timer_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] haddr,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic waveOutA,
    input wire logic waveOutAOe,
    input wire logic waveOutB,
    input wire logic waveOutBOe
);
    logic taken;
    logic dataWr;
    logic dataRd;
    assign taken = hsel && htrans[1] && hready;
    // ----------------------------------------
    // Data phase tracking
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        dataWr <= !rst && taken && hwrite;
        dataRd <= !rst && taken && !hwrite;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_wait;
        taken |=> s_wait;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state not one cycle");
    property p_fell;
        $fell(hreadyout) |-> $past(taken);
    endproperty
    a_fell: assert property (p_fell) else $error("stall without request");
    property p_rdata;
        !$stable(hrdata) |-> $past(dataRd);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    property p_byte;
        hrdata[31:8] == 24'h0;
    endproperty
    a_byte: assert property (p_byte) else $error("upper read bits set");
    property p_oe_a;
        !$stable(waveOutAOe) |-> $past(dataWr) || $past(dataWr, 2);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("pin A enable moved");
    property p_oe_b;
        !$stable(waveOutBOe) |-> $past(dataWr) || $past(dataWr, 2);
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("pin B enable moved");
    property p_reset;
        disable iff (1'b0) rst |=> hreadyout && hrdata == 32'h0 && !waveOutAOe && !waveOutBOe;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : dspt_timer_assertions
bind dspt_timer dspt_timer_assertions chk_u (.sys_clk(sys_clk), .rst(rst), .haddr(haddr),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .waveOutA(waveOutA),
    .waveOutAOe(waveOutAOe), .waveOutB(waveOutB), .waveOutBOe(waveOutBOe));
`default_nettype wire

// file: tb/dspt_bus_master.sv
/* Processor-side master of the timer's register bus.
   Assumes one slave whose hreadyout is fed back as hready. */
`timescale 1ns/10ps
`default_nettype none
module dspt_bus_master (
    input wire logic sys_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic [31:0] haddr,
    output logic hsel,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata
);
    initial begin
        haddr = 32'h0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
    end
    // ----------------------------------------
    // Transfers
    // ----------------------------------------
    // Waits are unbounded here; the bench watchdog ends a hang.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge sys_clk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata[7:0];
        // Released data lines show the inverse, never a stale copy.
        hwdata <= ~{24'h0, d};
    endtask : xfer
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        logic [7:0] q;
        xfer(a + 8'h04, 1'b1, v[15:8], q);
        xfer(a, 1'b1, v[7:0], q);
    endtask : wr16
endmodule : dspt_bus_master
`default_nettype wire

// file: tb/testbench.sv
/* Self-checking bench of the dual-slope PWM timer.
   Assumes the bus master model and the bound checker beside it. */
`timescale 1ns/10ps
`default_nettype none
`include "dspt_consts.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module testbench;
    import dspt_pkg::*;
    logic sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic waveOutA, waveOutAOe, waveOutB, waveOutBOe;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [7:0] seed, latch, q, adr;
    dspt_word_type mem [4];
    int fails, check_count, hi, lo;
    int divs [5] = '{1, 8, 64, 256, 1024};
    assign hready = hreadyout;
    dspt_timer dut_u (.sys_clk(sys_clk), .rst(rst), .haddr(haddr), .hsel(hsel),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .waveOutA(waveOutA),
        .waveOutAOe(waveOutAOe), .waveOutB(waveOutB), .waveOutBOe(waveOutBOe));
    dspt_bus_master master_u (.sys_clk(sys_clk), .hready(hready), .hrdata(hrdata),
        .haddr(haddr), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Bus tasks and byte-pair model
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        master_u.xfer(a, 1'b1, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        master_u.xfer(a, 1'b0, 8'h00, q);
        `CHK(n, e, q)
    endtask : rdc
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        int i;
        i = (a - 8'h10) >> 3;
        if (a[2]) latch = d;
        else mem[i] = {latch, d};
        wr(a, d);
    endtask : mwr
    task automatic mrd(input logic [7:0] a);
        int i;
        logic [7:0] e;
        i = (a - 8'h10) >> 3;
        e = a[2] ? ((i == 1 || i == 2) ? mem[i][15:8] : latch) : mem[i][7:0];
        if (!a[2] && i != 1 && i != 2) latch = mem[i][15:8];
        rdc(a, e, "byte pair");
    endtask : mrd
    task automatic run(input logic [7:0] mode, input logic [7:0] cfg,
        input dspt_word_type top, input dspt_word_type ca, input dspt_word_type cb);
        wr(`DSPT_OFS_CTRL_B, 8'h00);
        master_u.wr16(`DSPT_OFS_CMPA_LO, ca);
        master_u.wr16(`DSPT_OFS_CMPB_LO, cb);
        master_u.wr16(`DSPT_OFS_CAP_LO, top);
        master_u.wr16(`DSPT_OFS_CNT_LO, 16'h0000);
        wr(`DSPT_OFS_CTRL_A, cfg);
        wr(`DSPT_OFS_FLAGS, 8'h0f);
        wr(`DSPT_OFS_CTRL_B, mode);
    endtask : run
    task automatic waitlv(input logic s, input logic v, output int n);
        n = 0;
        while ((s ? waveOutA : waveOutB) !== v && n < 30000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : waitlv
    task automatic meas(input logic s);
        int n;
        waitlv(s, 1'b0, n);
        waitlv(s, 1'b1, n);
        waitlv(s, 1'b0, hi);
        waitlv(s, 1'b1, lo);
    endtask : meas
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        complete_run();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        fails = 0;
        check_count = 0;
        latch = 8'h00;
        seed = 8'h4c;
        for (int i = 0; i < 4; i++) mem[i] = 16'h0000;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (48) begin
            seed = lfsr(seed);
            adr = 8'h10 + {3'h0, seed[2:0], 2'b00};
            seed = lfsr(seed);
            if (seed[7]) mwr(adr, seed);
            else mrd(adr);
        end
        wr(8'h30, 8'h5a);
        rdc(8'h30, 8'h00, "unmapped");
        wr(`DSPT_OFS_PIN, 8'h0c);
        repeat (3) @(posedge sys_clk);
        `CHK("pins off", 4'b1010, {waveOutA, waveOutAOe, waveOutB, waveOutBOe})
        // Port bits high while the waves idle low, so a wrongly connected pin shows.
        wr(`DSPT_OFS_PIN, 8'h0f);
        wr(`DSPT_OFS_CTRL_A, 8'h50);
        repeat (3) @(posedge sys_clk);
        `CHK("pins on", 4'b1111, {waveOutA, waveOutAOe, waveOutB, waveOutBOe})
        // Capture holds the fixed top so compare A stays free for output.
        for (int p = 1; p <= 5; p++) begin
            run({1'b0, p[2:0], 4'h8}, 8'he0, 16'h0003, 16'h0001, 16'h0001);
            meas(1'b0);
            `CHK("noninv high", 2 * divs[p - 1], hi)
            `CHK("noninv low", 4 * divs[p - 1], lo)
            meas(1'b1);
            `CHK("inv high", 4 * divs[p - 1], hi)
            `CHK("inv low", 2 * divs[p - 1], lo)
        end
        run(8'h19, 8'h50, 16'h0009, 16'h0003, 16'h0001);
        meas(1'b1);
        `CHK("toggle period", 12, hi + lo)
        `CHK("reserved B", 1'b1, waveOutB)
        run(8'h19, 8'ha0, 16'h0009, 16'h0005, 16'h0002);
        meas(1'b0);
        `CHK("top A high", 4, hi)
        `CHK("top A low", 6, lo)
        wr(`DSPT_OFS_CTRL_B, 8'h00);
        rdc(`DSPT_OFS_FLAGS, 8'h07, "flags top A");
        run(8'h18, 8'ha0, 16'h0006, 16'h0002, 16'h0009);
        repeat (60) @(posedge sys_clk);
        wr(`DSPT_OFS_CTRL_B, 8'h00);
        rdc(`DSPT_OFS_FLAGS, 8'h0b, "flags capture");
        for (int i = 0; i < 2; i++) begin
            run(8'h18, i ? 8'hf0 : 8'ha0, 16'h0004, 16'h0000, 16'h0004);
            repeat (20) @(posedge sys_clk);
            repeat (16) begin
                @(posedge sys_clk);
                `CHK("extremes", {i[0], ~i[0]}, {waveOutA, waveOutB})
            end
        end
        complete_run();
    end
endmodule : testbench
`default_nettype wire
